/* File: src/aam_pkg.sv */
// Package with shared constants and types for the converter alarm monitor
//
// Contract
// - Conversion codes are straight binary in every range; negative full scale is all zeros.
// - Conversion code is 12 bits; one step is span over two to the twelfth.
// - Alarm drives the multifunction pin high only when function select equals 01b.
// - With alarm function on, input and supply alarms are enabled by default.
// - Input and supply alarms each have their own disable bit.
// - Each source keeps active and tripped flags; both set when it triggers.
// - Active flag clears at conversion end and sets again if condition persists.
// - Tripped flag holds until the alarm flag register is read, then clears.
// - All alarm flags update once at the end of every conversion.
// - Flags are supplied in any frame the host opens by pulling select low.
// - Selected flags may be appended after the conversion result in output data.
// - Input high alarm sets when code is strictly above the high threshold.
// - Input high alarm releases when code is at or below threshold minus hysteresis minus one.
// - Input low alarm sets when code is strictly below the low threshold.
// - Input low alarm releases when code is at or above threshold plus hysteresis plus one.
// - High and low thresholds are separate; one hysteresis value serves both.
// - Alarm pin goes high for any over or under condition on input or supply.
// - Supply high/low alarms follow the supply comparator's upper and lower trip reports.

`default_nettype none

package aam_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int AAM_CODE_W = 12;
    localparam int AAM_HYST_W = 4;
    localparam int AAM_SRC_N = 4;
    // Widened signed width for threshold arithmetic
    localparam int AAM_WIDE_W = AAM_CODE_W + 2;

    // ========================================================================
    // Field values
    // ========================================================================
    localparam logic [1:0] AAM_PIN_FUNC_ALARM = 2'h1;
    localparam logic [1:0] AAM_APPEND_NONE = 2'h0;
    localparam logic [1:0] AAM_APPEND_ACTIVE = 2'h1;
    localparam logic [1:0] AAM_APPEND_TRIPPED = 2'h2;
    localparam logic [1:0] AAM_APPEND_BOTH = 2'h3;
    localparam logic [AAM_WIDE_W-1:0] AAM_RELEASE_STEP = 14'h0001;

    // Reset values
    localparam logic [AAM_SRC_N-1:0] AAM_FLAGS_RST = 4'h0;

    // Source index order inside every flag vector
    localparam int AAM_SRC_IN_HIGH = 0;
    localparam int AAM_SRC_IN_LOW = 1;
    localparam int AAM_SRC_SUP_HIGH = 2;
    localparam int AAM_SRC_SUP_LOW = 3;

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic [AAM_SRC_N-1:0] tripped;
        logic [AAM_SRC_N-1:0] active;
    } aam_flags_t;

    typedef struct packed {
        logic [AAM_CODE_W-1:0] code;
        logic [AAM_SRC_N-1:0] activeTail;
        logic [AAM_SRC_N-1:0] trippedTail;
    } aam_stream_t;

    typedef enum logic [0:0] {
        AAM_FRAME_IDLE = 1'b0,
        AAM_FRAME_OPEN = 1'b1
    } aam_frame_t;

endpackage : aam_pkg

`default_nettype wire

/* File: src/aam_input_compare.sv */
// Threshold comparator with shared hysteresis for the input alarms
`timescale 1ns/1ps
`default_nettype none

module aam_input_compare
    import aam_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstN,
    input wire logic convDone,
    input wire logic watchDisable,
    input wire logic [AAM_CODE_W-1:0] convCode,
    input wire logic [AAM_CODE_W-1:0] upperLimitWord,
    input wire logic [AAM_CODE_W-1:0] lowerLimitWord,
    input wire logic [AAM_HYST_W-1:0] hysteresis,
    output logic highCond,
    output logic lowCond
);

    // ========================================================================
    // Widened compare values
    // ========================================================================
    // Signed 14-bit math keeps T-H-1 and T+H+1 from wrapping at the code ends
    logic signed [AAM_WIDE_W-1:0] codeWide;
    logic signed [AAM_WIDE_W-1:0] upperWide;
    logic signed [AAM_WIDE_W-1:0] lowerWide;
    logic signed [AAM_WIDE_W-1:0] hystWide;
    logic signed [AAM_WIDE_W-1:0] highRelease;
    logic signed [AAM_WIDE_W-1:0] lowRelease;
    wire highSet;
    wire highClear;
    wire lowSet;
    wire lowClear;
    logic next_highCond;
    logic next_lowCond;

    assign codeWide = signed'({{(AAM_WIDE_W-AAM_CODE_W){1'b0}}, convCode});
    assign upperWide = signed'({{(AAM_WIDE_W-AAM_CODE_W){1'b0}}, upperLimitWord});
    assign lowerWide = signed'({{(AAM_WIDE_W-AAM_CODE_W){1'b0}}, lowerLimitWord});
    assign hystWide = signed'({{(AAM_WIDE_W-AAM_HYST_W){1'b0}}, hysteresis});
    assign highRelease = upperWide - hystWide - signed'(AAM_RELEASE_STEP);
    assign lowRelease = lowerWide + hystWide + signed'(AAM_RELEASE_STEP);

    // Both limits come from separate words, one hysteresis serves both
    assign highSet = codeWide > upperWide;
    assign highClear = codeWide <= highRelease;
    assign lowSet = codeWide < lowerWide;
    assign lowClear = codeWide >= lowRelease;

    // Between set and release the previous state holds
    assign next_highCond = watchDisable ? 1'b0 : (highSet | (highCond & ~highClear));
    assign next_lowCond = watchDisable ? 1'b0 : (lowSet | (lowCond & ~lowClear));

    // State moves only on a finished conversion
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            highCond <= 1'b0;
            lowCond <= 1'b0;
        end
        else if (convDone)
        begin
            highCond <= next_highCond;
            lowCond <= next_lowCond;
        end
    end

endmodule : aam_input_compare

`default_nettype wire

/* File: src/aam_alarm_monitor.sv */
// Top of the converter alarm monitor: flags, alarm pin, frame snapshot, output stream
`timescale 1ns/1ps
`default_nettype none

module aam_alarm_monitor
    import aam_pkg::*;
#(
    parameter int CODE_W = AAM_CODE_W,
    parameter int HYST_W = AAM_HYST_W
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Converter result, one pulse per finished conversion
    input wire logic convDone,
    input wire logic [CODE_W-1:0] convCode,
    // Supply comparator reports
    input wire logic analogSupplyAbove,
    input wire logic analogSupplyBelow,
    // Configuration bits
    input wire logic [1:0] secondOutFunctionSel,
    input wire logic inputWatchDisable,
    input wire logic supplyWatchDisable,
    input wire logic [CODE_W-1:0] upperLimitWord,
    input wire logic [CODE_W-1:0] lowerLimitWord,
    input wire logic [HYST_W-1:0] hysteresis,
    input wire logic [1:0] outputFormatControlWord,
    // Host side
    input wire logic conversionSelectPin,
    input wire logic flagRead,
    // Results
    output logic multifunctionOutPin,
    output logic alarmPinDrive,
    output aam_flags_t flagWord,
    output aam_flags_t frameFlags,
    output logic frameFlagsValid,
    output aam_stream_t streamWord,
    output logic [4:0] streamLength
);

    // ========================================================================
    // Reset release
    // ========================================================================
    logic rstMeta;
    logic rstN;

    // Two stages so release never lands mid-edge on the rest of the logic
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // ========================================================================
    // Input threshold comparators
    // ========================================================================
    logic inHighCond;
    logic inLowCond;

    aam_input_compare u_input_compare (
        .core_clk(core_clk),
        .rstN(rstN),
        .convDone(convDone),
        .watchDisable(inputWatchDisable),
        .convCode(convCode),
        .upperLimitWord(upperLimitWord),
        .lowerLimitWord(lowerLimitWord),
        .hysteresis(hysteresis),
        .highCond(inHighCond),
        .lowCond(inLowCond)
    );

    // ========================================================================
    // Per-source conditions and enables
    // ========================================================================
    // Both watches are on unless software sets a disable bit
    wire [AAM_SRC_N-1:0] srcEnable;
    wire [AAM_SRC_N-1:0] srcCond;

    assign srcEnable[AAM_SRC_IN_HIGH] = ~inputWatchDisable;
    assign srcEnable[AAM_SRC_IN_LOW] = ~inputWatchDisable;
    assign srcEnable[AAM_SRC_SUP_HIGH] = ~supplyWatchDisable;
    assign srcEnable[AAM_SRC_SUP_LOW] = ~supplyWatchDisable;

    assign srcCond[AAM_SRC_IN_HIGH] = inHighCond;
    assign srcCond[AAM_SRC_IN_LOW] = inLowCond;
    assign srcCond[AAM_SRC_SUP_HIGH] = analogSupplyAbove;
    assign srcCond[AAM_SRC_SUP_LOW] = analogSupplyBelow;

    // ========================================================================
    // Active and tripped flags
    // ========================================================================
    // Comparator output lags convDone by one cycle, so flags update a cycle later
    logic flagUpdate;
    logic [AAM_SRC_N-1:0] activeFlag;
    logic [AAM_SRC_N-1:0] trippedFlag;
    logic [AAM_SRC_N-1:0] next_activeFlag;
    logic [AAM_SRC_N-1:0] next_trippedFlag;

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            flagUpdate <= 1'b0;
            activeFlag <= AAM_FLAGS_RST;
            trippedFlag <= AAM_FLAGS_RST;
        end
        else
        begin
            flagUpdate <= convDone;
            activeFlag <= next_activeFlag;
            trippedFlag <= next_trippedFlag;
        end
    end

    genvar src;
    generate
        for (src = 0; src < AAM_SRC_N; src++)
        begin : g_src
            wire trigger;

            // A disabled source never raises either flag
            assign trigger = srcCond[src] & srcEnable[src];

            // Active follows the condition at every conversion end
            assign next_activeFlag[src] = flagUpdate ? trigger : activeFlag[src];

            // Set beats the read clear so an alarm in the read cycle survives
            assign next_trippedFlag[src] = (flagUpdate & trigger) ? 1'b1 :
                                           (flagRead ? 1'b0 : trippedFlag[src]);
        end
    endgenerate

    // ========================================================================
    // Flag readback word
    // ========================================================================
    // Read data shows the flags as they were before the read clears tripped
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            flagWord <= '{tripped: AAM_FLAGS_RST, active: AAM_FLAGS_RST};
        end
        else
        begin
            flagWord <= '{tripped: trippedFlag, active: activeFlag};
        end
    end

    // ========================================================================
    // Alarm pin
    // ========================================================================
    wire alarmAny;
    wire pinIsAlarm;
    logic next_multifunctionOutPin;

    // Any enabled active flag raises the pin, usable as host interrupt
    assign alarmAny = |activeFlag;
    assign pinIsAlarm = secondOutFunctionSel == AAM_PIN_FUNC_ALARM;
    // Other pin functions live outside this block; here the pin idles low
    assign next_multifunctionOutPin = pinIsAlarm & alarmAny;

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            multifunctionOutPin <= 1'b0;
            alarmPinDrive <= 1'b0;
        end
        else
        begin
            multifunctionOutPin <= next_multifunctionOutPin;
            alarmPinDrive <= pinIsAlarm;
        end
    end

    // ========================================================================
    // Frame tracking
    // ========================================================================
    // A frame opens when the select pin goes low; flags are frozen then
    aam_frame_t frameState;
    aam_frame_t next_frameState;
    wire frameOpen;

    always_comb
    begin
        next_frameState = frameState;
        case (frameState)
            AAM_FRAME_IDLE:
            begin
                if (!conversionSelectPin)
                begin
                    next_frameState = AAM_FRAME_OPEN;
                end
            end
            AAM_FRAME_OPEN:
            begin
                if (conversionSelectPin)
                begin
                    next_frameState = AAM_FRAME_IDLE;
                end
            end
            default:
            begin
                next_frameState = AAM_FRAME_IDLE;
            end
        endcase
    end

    assign frameOpen = (frameState == AAM_FRAME_IDLE) & ~conversionSelectPin;

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            frameState <= AAM_FRAME_IDLE;
            frameFlags <= '{tripped: AAM_FLAGS_RST, active: AAM_FLAGS_RST};
            frameFlagsValid <= 1'b0;
        end
        else
        begin
            frameState <= next_frameState;
            if (frameOpen)
            begin
                frameFlags <= '{tripped: trippedFlag, active: activeFlag};
            end
            frameFlagsValid <= next_frameState == AAM_FRAME_OPEN;
        end
    end

    // ========================================================================
    // Output data stream
    // ========================================================================
    // Result leads; selected flag groups follow, unselected tails read zero
    wire appendActive;
    wire appendTripped;
    logic [4:0] next_streamLength;

    assign appendActive = (outputFormatControlWord == AAM_APPEND_ACTIVE) |
                          (outputFormatControlWord == AAM_APPEND_BOTH);
    assign appendTripped = (outputFormatControlWord == AAM_APPEND_TRIPPED) |
                           (outputFormatControlWord == AAM_APPEND_BOTH);
    assign next_streamLength = 5'(CODE_W) + (appendActive ? 5'(AAM_SRC_N) : 5'h0) +
                               (appendTripped ? 5'(AAM_SRC_N) : 5'h0);

    // Stream is built on the flag update edge from the next flag values, so flags are fresh
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            streamWord <= '0;
            streamLength <= 5'(CODE_W);
        end
        else if (flagUpdate)
        begin
            streamWord.code <= convCode;
            streamWord.activeTail <= appendActive ? next_activeFlag : AAM_FLAGS_RST;
            streamWord.trippedTail <= appendTripped ? next_trippedFlag : AAM_FLAGS_RST;
            streamLength <= next_streamLength;
        end
    end

endmodule : aam_alarm_monitor

`default_nettype wire

/* File: verification/aam_alarm_monitor_checker.sv */
// Port checker for the converter alarm monitor
`timescale 1ns/1ps
`default_nettype none

module aam_alarm_monitor_checker
    import aam_pkg::*;
#(
    parameter int CODE_W = AAM_CODE_W,
    parameter int HYST_W = AAM_HYST_W
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic convDone,
    input wire logic [CODE_W-1:0] convCode,
    input wire logic analogSupplyAbove,
    input wire logic [1:0] secondOutFunctionSel,
    input wire logic inputWatchDisable,
    input wire logic supplyWatchDisable,
    input wire logic [CODE_W-1:0] upperLimitWord,
    input wire logic [CODE_W-1:0] lowerLimitWord,
    input wire logic [HYST_W-1:0] hysteresis,
    input wire logic [1:0] outputFormatControlWord,
    input wire logic conversionSelectPin,
    input wire logic flagRead,
    input wire logic multifunctionOutPin,
    input wire logic alarmPinDrive,
    input wire aam_flags_t flagWord,
    input wire aam_flags_t frameFlags,
    input wire logic frameFlagsValid,
    input wire logic [4:0] streamLength
);
    // ========================================================================
    // Helpers
    // ========================================================================
    // Two spare bits stop the release sums wrapping
    logic [CODE_W+1:0] codeWide;
    logic [CODE_W+1:0] hystWide;
    logic highRelease;
    logic lowRelease;
    logic [4:0] expLen;
    assign codeWide = {2'b00, convCode};
    assign hystWide = {{(CODE_W+2-HYST_W){1'b0}}, hysteresis};
    assign highRelease = (codeWide + hystWide + 1) <= {2'b00, upperLimitWord};
    assign lowRelease = codeWide >= ({2'b00, lowerLimitWord} + hystWide + 1);
    assign expLen = (outputFormatControlWord == 2'h0) ? 5'h0C : (outputFormatControlWord == 2'h3) ? 5'h14 : 5'h10;

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // ========================================================================
    // Assertions
    // ========================================================================
    a_high_sets: assert property (
        convDone && !inputWatchDisable && convCode > upperLimitWord |-> ##3 flagWord.active[AAM_SRC_IN_HIGH])
        else $error("input high alarm not raised");
    a_high_release: assert property (
        convDone && highRelease |-> ##3 !flagWord.active[AAM_SRC_IN_HIGH])
        else $error("input high alarm not released");
    a_low_sets: assert property (
        convDone && !inputWatchDisable && convCode < lowerLimitWord |-> ##3 flagWord.active[AAM_SRC_IN_LOW])
        else $error("input low alarm not raised");
    a_low_release: assert property (
        convDone && lowRelease |-> ##3 !flagWord.active[AAM_SRC_IN_LOW])
        else $error("input low alarm not released");
    a_supply_high: assert property (
        convDone ##1 (analogSupplyAbove && !supplyWatchDisable) |-> ##2 flagWord.active[AAM_SRC_SUP_HIGH])
        else $error("supply high alarm not raised");
    a_input_disabled: assert property (
        convDone && inputWatchDisable |-> ##3 flagWord.active[1:0] == 2'h0)
        else $error("disabled input alarm set a flag");
    a_set_both: assert property (
        (flagWord.active & ~$past(flagWord.active) & ~flagWord.tripped) == 4'h0)
        else $error("active flag rose without tripped flag");
    a_update_timing: assert property (
        flagWord.active != $past(flagWord.active) |-> $past(convDone, 3))
        else $error("active flags changed outside a conversion end");
    a_tripped_hold: assert property (
        ($past(flagWord.tripped) & ~flagWord.tripped) != 4'h0 |-> $past(flagRead, 2))
        else $error("tripped flag cleared without a read");
    a_pin_function: assert property (
        multifunctionOutPin |-> alarmPinDrive && $past(secondOutFunctionSel) == AAM_PIN_FUNC_ALARM)
        else $error("alarm pin high outside alarm function");
    a_pin_or: assert property (
        alarmPinDrive |-> multifunctionOutPin == (|flagWord.active))
        else $error("alarm pin differs from active flags");
    a_frame_open: assert property (
        $fell(conversionSelectPin) |=> frameFlagsValid && frameFlags == flagWord)
        else $error("frame flags not supplied");
    a_frame_close: assert property (
        conversionSelectPin |=> !frameFlagsValid)
        else $error("frame valid after select high");
    a_stream_length: assert property (
        convDone |-> ##3 streamLength == expLen)
        else $error("stream length does not match format");
endmodule : aam_alarm_monitor_checker

bind aam_alarm_monitor aam_alarm_monitor_checker #(.CODE_W(CODE_W), .HYST_W(HYST_W)) i_aam_alarm_monitor_checker (
    .core_clk(core_clk), .resetn(resetn), .convDone(convDone), .convCode(convCode),
    .analogSupplyAbove(analogSupplyAbove), .secondOutFunctionSel(secondOutFunctionSel),
    .inputWatchDisable(inputWatchDisable), .supplyWatchDisable(supplyWatchDisable),
    .upperLimitWord(upperLimitWord), .lowerLimitWord(lowerLimitWord), .hysteresis(hysteresis),
    .outputFormatControlWord(outputFormatControlWord), .conversionSelectPin(conversionSelectPin),
    .flagRead(flagRead), .multifunctionOutPin(multifunctionOutPin), .alarmPinDrive(alarmPinDrive),
    .flagWord(flagWord), .frameFlags(frameFlags), .frameFlagsValid(frameFlagsValid), .streamLength(streamLength));

`default_nettype wire

/* File: verification/aam_host_model.sv */
// Host controller model: frame select pin and flag register reads
`timescale 1ns/1ps
`default_nettype none

module aam_host_model
(
    input wire logic core_clk,
    output logic conversionSelectPin,
    output logic flagRead
);
    // ========================================================================
    // Host actions
    // ========================================================================
    // Idle host keeps the frame closed
    initial
    begin
        conversionSelectPin = 1'b1;
        flagRead = 1'b0;
    end

    // Changes land on the falling edge, settled for the rising edge
    task automatic openFrame();
        @(negedge core_clk);
        conversionSelectPin = 1'b0;
    endtask : openFrame

    task automatic closeFrame();
        @(negedge core_clk);
        conversionSelectPin = 1'b1;
    endtask : closeFrame

    // One-cycle read strobe that clears tripped flags
    task automatic readFlags();
        @(negedge core_clk);
        flagRead = 1'b1;
        @(negedge core_clk);
        flagRead = 1'b0;
    endtask : readFlags
endmodule : aam_host_model

`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the converter alarm monitor
`timescale 1ns/1ps
`default_nettype none

module tb
    import aam_pkg::*;
;
    // ========================================================================
    // Signals and instances
    // ========================================================================
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic convDone = 1'b0;
    logic [AAM_CODE_W-1:0] convCode = 12'h000;
    logic analogSupplyAbove = 1'b0;
    logic analogSupplyBelow = 1'b0;
    logic [1:0] secondOutFunctionSel = 2'h1;
    logic inputWatchDisable = 1'b0;
    logic supplyWatchDisable = 1'b0;
    logic [AAM_CODE_W-1:0] upperLimitWord = 12'h800;
    logic [AAM_CODE_W-1:0] lowerLimitWord = 12'h100;
    logic [AAM_HYST_W-1:0] hysteresis = 4'h2;
    logic [1:0] outputFormatControlWord = 2'h3;
    logic conversionSelectPin, flagRead, multifunctionOutPin, alarmPinDrive, frameFlagsValid;
    aam_flags_t flagWord, frameFlags;
    aam_stream_t streamWord;
    logic [4:0] streamLength;
    logic [47:0] rows [11];
    int errors = 0;
    int n_tests = 0;

    always #10 core_clk = ~core_clk;

    aam_alarm_monitor i_aam_alarm_monitor (
        .core_clk(core_clk), .resetn(resetn), .convDone(convDone), .convCode(convCode),
        .analogSupplyAbove(analogSupplyAbove), .analogSupplyBelow(analogSupplyBelow),
        .secondOutFunctionSel(secondOutFunctionSel), .inputWatchDisable(inputWatchDisable),
        .supplyWatchDisable(supplyWatchDisable), .upperLimitWord(upperLimitWord),
        .lowerLimitWord(lowerLimitWord), .hysteresis(hysteresis),
        .outputFormatControlWord(outputFormatControlWord), .conversionSelectPin(conversionSelectPin),
        .flagRead(flagRead), .multifunctionOutPin(multifunctionOutPin), .alarmPinDrive(alarmPinDrive),
        .flagWord(flagWord), .frameFlags(frameFlags), .frameFlagsValid(frameFlagsValid),
        .streamWord(streamWord), .streamLength(streamLength));

    aam_host_model i_aam_host_model (
        .core_clk(core_clk), .conversionSelectPin(conversionSelectPin), .flagRead(flagRead));

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One conversion; returns once flags reach the ports
    task automatic conv(input logic [AAM_CODE_W-1:0] code);
        @(negedge core_clk);
        convDone = 1'b1;
        convCode = code;
        @(negedge core_clk);
        convDone = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : conv

    task automatic readAll();
        i_aam_host_model.readFlags();
        repeat (2) @(negedge core_clk);
    endtask : readAll

    task automatic summarize();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // ========================================================================
    // Tests
    // ========================================================================
    // Rows: hysteresis, upper limit, lower limit, code, expected flags
    initial
    begin
        rows = '{48'h2800_1008_0111, 48'h2800_1007_FE11, 48'h2800_1007_FD10, 48'h2800_1008_0010,
                 48'h2800_1000_FF32, 48'h2800_1001_0232, 48'h2800_1001_0330, 48'h2800_1001_0030,
                 48'hF000_FFF0_0022, 48'hF000_FFFF_FF33, 48'hF000_FFF0_0033};
        repeat (6) @(negedge core_clk);
        check({27'h0, streamLength}, 32'h0000_000C);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        for (int i = 0; i < 11; i++)
        begin
            if (i == 8)
            begin
                readAll();
                check({24'h0, flagWord}, 32'h0000_0000);
            end
            {hysteresis, upperLimitWord, lowerLimitWord} = rows[i][47:20];
            conv(rows[i][19:8]);
            check({24'h0, flagWord}, {24'h0, rows[i][7:0]});
            check({12'h0, streamWord}, {12'h0, rows[i][19:8], rows[i][3:0], rows[i][7:4]});
        end
        // Supply reports, with the input inside its window
        {hysteresis, upperLimitWord, lowerLimitWord} = 28'h2800_100;
        readAll();
        analogSupplyAbove = 1'b1;
        conv(12'h400);
        check({24'h0, flagWord}, 32'h0000_0044);
        check({31'h0, multifunctionOutPin}, 32'h0000_0001);
        analogSupplyAbove = 1'b0;
        analogSupplyBelow = 1'b1;
        conv(12'h400);
        check({24'h0, flagWord}, 32'h0000_00C8);
        // Both sources disabled: faults stay silent
        analogSupplyBelow = 1'b0;
        analogSupplyAbove = 1'b1;
        inputWatchDisable = 1'b1;
        supplyWatchDisable = 1'b1;
        readAll();
        conv(12'hFFF);
        check({23'h0, multifunctionOutPin, flagWord}, 32'h0000_0000);
        analogSupplyAbove = 1'b0;
        inputWatchDisable = 1'b0;
        supplyWatchDisable = 1'b0;
        // Every pin function and every stream format
        for (int f = 0; f < 4; f++)
        begin
            secondOutFunctionSel = 2'(f);
            outputFormatControlWord = 2'(f);
            conv(12'hFFF);
            check({30'h0, alarmPinDrive, multifunctionOutPin}, (f == 1) ? 32'h0000_0003 : 32'h0000_0000);
            check({27'h0, streamLength}, (f == 0) ? 32'h0000_000C : (f == 3) ? 32'h0000_0014 : 32'h0000_0010);
            check({12'h0, streamWord}, {12'h0, 12'hFFF, 3'h0, f[0], 3'h0, f[1]});
        end
        // Frame snapshot stands while flags move on
        i_aam_host_model.openFrame();
        repeat (2) @(negedge core_clk);
        check({23'h0, frameFlagsValid, frameFlags}, 32'h0000_0111);
        conv(12'h400);
        check({23'h0, frameFlagsValid, frameFlags}, 32'h0000_0111);
        check({24'h0, flagWord}, 32'h0000_0010);
        i_aam_host_model.closeFrame();
        repeat (2) @(negedge core_clk);
        check({31'h0, frameFlagsValid}, 32'h0000_0000);
        summarize();
    end

    // Run is about 120 cycles; 3000 is some twenty-four times that and means a hang
    initial
    begin
        repeat (3000) @(posedge core_clk);
        errors++;
        summarize();
    end
endmodule : tb

`default_nettype wire
